/* File: rtl/pmss_regs.sv */
// port mirror control and address security status registers over AXI4-Lite
`timescale 1ns/1ps
module pmss_regs
  import pmss_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [pmss_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [pmss_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [pmss_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [pmss_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] low_ports_copy_sel,
  input wire logic [2:0] monitor_port,
  input wire logic frm_valid,
  input wire logic [2:0] frm_src_port,
  input wire logic [pmss_pkg::NPORT-1:0] frm_dst_ports,
  input wire logic frm_da_match,
  input wire logic frm_sa_match,
  input wire logic frm_bad_checksum,
  input wire logic frm_receive_error,
  input wire logic frm_pause,
  input wire logic frm_oversize,
  input wire logic frm_undersize,
  output logic frm_out_valid,
  output logic [pmss_pkg::NPORT-1:0] frm_out_ports,
  output logic frm_out_mirrored,
  input wire logic [pmss_pkg::NPORT-1:0] intrusion_evt,
  input wire logic [pmss_pkg::NPORT-1:0] address_locked_flags,
  input wire logic [pmss_pkg::NPORT-1:0] port_closed_flags,
  input wire logic [pmss_pkg::NPORT-1:0] link_lock_flags,
  output logic lock_lookup_start,
  output logic [2:0] lock_lookup_port
);
  import pmss_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  logic [15:0] mirror_ctrl_ff;
  logic [NPORT-1:0] intrusion_seen_flags_ff;
  logic [NPORT-1:0] address_locked_ff;
  logic [NPORT-1:0] port_closed_ff;
  logic [NPORT-1:0] link_lock_ff;
  logic [2:0] lock_lookup_port_sel_ff;
  logic lock_lookup_start_ff;
  logic [2:0] lock_lookup_port_ff;
  logic aw_got_ff;
  logic w_got_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic frm_out_valid_ff;
  logic [NPORT-1:0] frm_out_ports_ff;
  logic frm_out_mirrored_ff;

  // ****************************************
  // write channel decode
  // ****************************************
  wire aw_hs = s_axi_awvalid & awready_ff;
  wire w_hs = s_axi_wvalid & wready_ff;
  wire nxt_aw_got = aw_got_ff | aw_hs;
  wire nxt_w_got = w_got_ff | w_hs;
  wire [ADDR_W-1:0] wr_addr = aw_hs ? s_axi_awaddr : awaddr_ff;
  wire [DATA_W-1:0] wr_data = w_hs ? s_axi_wdata : wdata_ff;
  wire [3:0] wr_strb = w_hs ? s_axi_wstrb : wstrb_ff;
  // write fires once both halves are held and the old response is gone
  wire wr_fire = nxt_aw_got & nxt_w_got & ~bvalid_ff;
  wire [9:0] wr_idx = wr_addr[ADDR_W-1:2];
  wire [15:0] wr_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire wr_mirror = wr_idx == IDX_MIRROR_CTRL_UPPER;
  wire wr_search = wr_idx == IDX_LOCK_SEARCH_PORT_SEL;
  // status registers are read only; writes to them are accepted and dropped
  wire wr_known = wr_mirror | wr_search | (wr_idx == IDX_INTRUSION_FLAGS)
    | (wr_idx == IDX_LOCK_STATUS_FIRST) | (wr_idx == IDX_LOCK_STATUS_SECOND);
  wire [15:0] nxt_mirror_ctrl = (mirror_ctrl_ff & ~(wr_mask & MIRROR_CTRL_WMASK))
    | (wr_data[15:0] & wr_mask & MIRROR_CTRL_WMASK);
  wire search_wr = wr_fire & wr_search & wr_strb[0];
  wire [2:0] nxt_search_port = wr_data[2:0];
  wire search_valid = nxt_search_port <= LAST_PORT_CODE;
  wire nxt_bvalid = wr_fire | (bvalid_ff & ~s_axi_bready);
  wire nxt_aw_got_hold = nxt_aw_got & ~wr_fire;
  wire nxt_w_got_hold = nxt_w_got & ~wr_fire;

  // ****************************************
  // read channel decode
  // ****************************************
  wire ar_hs = s_axi_arvalid & arready_ff;
  wire [9:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
  wire rd_mirror = rd_idx == IDX_MIRROR_CTRL_UPPER;
  wire rd_intr = rd_idx == IDX_INTRUSION_FLAGS;
  wire rd_st0 = rd_idx == IDX_LOCK_STATUS_FIRST;
  wire rd_st1 = rd_idx == IDX_LOCK_STATUS_SECOND;
  wire rd_search = rd_idx == IDX_LOCK_SEARCH_PORT_SEL;
  wire rd_known = rd_mirror | rd_intr | rd_st0 | rd_st1 | rd_search;
  wire [15:0] rd_intr_word = 16'(intrusion_seen_flags_ff) << F_HIGH_FLAGS_LO;
  wire [15:0] rd_st0_word = (16'(address_locked_ff) << F_HIGH_FLAGS_LO)
    | (16'(port_closed_ff) << F_LOW_FLAGS_LO);
  wire [15:0] rd_st1_word = 16'(link_lock_ff) << F_LOW_FLAGS_LO;
  wire [15:0] rd_word = ({16{rd_mirror}} & mirror_ctrl_ff)
    | ({16{rd_intr}} & rd_intr_word) | ({16{rd_st0}} & rd_st0_word)
    | ({16{rd_st1}} & rd_st1_word) | ({16{rd_search}} & 16'(lock_lookup_port_sel_ff));
  wire intr_clear = ar_hs & rd_intr;
  wire nxt_rvalid = ar_hs | (rvalid_ff & ~s_axi_rready);

  // ****************************************
  // mirror selection per port
  // ****************************************
  wire [15:0] ctrl = mirror_ctrl_ff;
  wire [4*NPORT-1:0] all_sel = {ctrl[F_PORT5_EGRESS_LO+:2], ctrl[F_PORT5_INGRESS_LO+:2],
    ctrl[F_PORT4_EGRESS_LO+:2], ctrl[F_PORT4_INGRESS_LO+:2], low_ports_copy_sel};
  logic [NPORT-1:0] egress_hit;
  logic [NPORT-1:0] ingress_hit;
  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      wire [1:0] in_sel = all_sel[4*gp+:2];
      wire [1:0] eg_sel = all_sel[4*gp+2+:2];
      assign egress_hit[gp] = (eg_sel == SEL_ALL) | ((eg_sel == SEL_DA_MATCH) & frm_da_match)
        | ((eg_sel == SEL_SA_MATCH) & frm_sa_match);
      assign ingress_hit[gp] = (in_sel == SEL_ALL) | ((in_sel == SEL_DA_MATCH) & frm_da_match)
        | ((in_sel == SEL_SA_MATCH) & frm_sa_match);
    end
  endgenerate
  wire src_hit = (frm_src_port < 3'(NPORT)) & ingress_hit[frm_src_port];
  wire dst_hit = |(egress_hit & frm_dst_ports);
  // abnormal classes are dropped from the copy unless their own bit lets them through
  wire drop_bad_checksum = frm_bad_checksum & ~ctrl[B_COPY_BAD_CHECKSUM];
  wire drop_receive_error = frm_receive_error & ~ctrl[B_COPY_RECEIVE_ERROR];
  wire drop_flow_control = frm_pause & ~ctrl[B_COPY_FLOW_CONTROL];
  wire drop_oversize = frm_oversize & ~ctrl[B_COPY_OVERSIZE];
  wire drop_undersize = frm_undersize & ~ctrl[B_COPY_UNDERSIZE];
  wire class_ok = ~(drop_bad_checksum | drop_receive_error | drop_flow_control
    | drop_oversize | drop_undersize);
  wire selected = ctrl[B_MIRRORING_ON] & (src_hit | dst_hit) & class_ok;
  wire [NPORT-1:0] mon_bit = (monitor_port < 3'(NPORT)) ? NPORT'(1) << monitor_port : '0;
  wire mon_in_dst = |(frm_dst_ports & mon_bit);
  wire mon_copy = selected | (ctrl[B_FORWARD_UNMONITORED] & mon_in_dst);
  // with mirroring off the monitor port is an ordinary port
  wire [NPORT-1:0] nxt_out_ports = ctrl[B_MIRRORING_ON] ?
    ((frm_dst_ports & ~mon_bit) | (mon_copy ? mon_bit : '0)) : frm_dst_ports;

  // ****************************************
  // bus state
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
    end else begin
      aw_got_ff <= nxt_aw_got_hold;
      w_got_ff <= nxt_w_got_hold;
      awready_ff <= ~nxt_aw_got_hold & ~nxt_bvalid;
      wready_ff <= ~nxt_w_got_hold & ~nxt_bvalid;
      bvalid_ff <= nxt_bvalid;
    end
  end

  // code only moves with a new write, so it stands with bvalid
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bresp_ff <= RESP_OKAY;
    end else if (wr_fire) begin
      bresp_ff <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      awaddr_ff <= '0;
    end else if (aw_hs) begin
      awaddr_ff <= s_axi_awaddr;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdata_ff <= '0;
      wstrb_ff <= 4'h0;
    end else if (w_hs) begin
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
    end else begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= '0;
      rresp_ff <= RESP_OKAY;
    end else if (ar_hs) begin
      rdata_ff <= DATA_W'(rd_word);
      rresp_ff <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ****************************************
  // control and status registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mirror_ctrl_ff <= RST_MIRROR_CTRL_UPPER;
    end else if (wr_fire & wr_mirror) begin
      mirror_ctrl_ff <= nxt_mirror_ctrl;
    end
  end

  // unused codes are kept so software reads back what it wrote
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_lookup_port_sel_ff <= RST_LOCK_SEARCH_PORT_SEL;
    end else if (search_wr) begin
      lock_lookup_port_sel_ff <= nxt_search_port;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_lookup_start_ff <= 1'b0;
    end else begin
      lock_lookup_start_ff <= search_wr & search_valid;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_lookup_port_ff <= RST_LOCK_SEARCH_PORT_SEL;
    end else if (search_wr & search_valid) begin
      lock_lookup_port_ff <= nxt_search_port;
    end
  end

  // a fresh event in the clearing cycle survives the read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      intrusion_seen_flags_ff <= '0;
    end else begin
      intrusion_seen_flags_ff <= (intrusion_seen_flags_ff & ~{NPORT{intr_clear}})
        | intrusion_evt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      address_locked_ff <= '0;
      port_closed_ff <= '0;
      link_lock_ff <= '0;
    end else begin
      address_locked_ff <= address_locked_flags;
      port_closed_ff <= port_closed_flags;
      link_lock_ff <= link_lock_flags;
    end
  end

  // ****************************************
  // frame decision, one cycle after the descriptor
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frm_out_valid_ff <= 1'b0;
    end else begin
      frm_out_valid_ff <= frm_valid;
    end
  end

  // decision stands until the next descriptor
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frm_out_ports_ff <= '0;
      frm_out_mirrored_ff <= 1'b0;
    end else if (frm_valid) begin
      frm_out_ports_ff <= nxt_out_ports;
      frm_out_mirrored_ff <= selected;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign frm_out_valid = frm_out_valid_ff;
  assign frm_out_ports = frm_out_ports_ff;
  assign frm_out_mirrored = frm_out_mirrored_ff;
  assign lock_lookup_start = lock_lookup_start_ff;
  assign lock_lookup_port = lock_lookup_port_ff;
endmodule

/* File: rtl/pmss_pkg.sv */
// constants for the port mirror and address security register bank
package pmss_pkg;
  // ****************************************
  // bus and register map (index, byte address = 4 * index)
  // ****************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int NPORT = 6;
  localparam logic [9:0] IDX_MIRROR_CTRL_UPPER = 10'h137;
  localparam logic [9:0] IDX_INTRUSION_FLAGS = 10'h138;
  localparam logic [9:0] IDX_LOCK_STATUS_FIRST = 10'h139;
  localparam logic [9:0] IDX_LOCK_STATUS_SECOND = 10'h13A;
  localparam logic [9:0] IDX_LOCK_SEARCH_PORT_SEL = 10'h13B;
  localparam logic [15:0] RST_MIRROR_CTRL_UPPER = 16'h0000;
  localparam logic [2:0] RST_LOCK_SEARCH_PORT_SEL = 3'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************
  // mirror control fields
  // ****************************************
  localparam int B_MIRRORING_ON = 15;
  localparam int B_COPY_BAD_CHECKSUM = 14;
  localparam int B_COPY_RECEIVE_ERROR = 13;
  localparam int B_COPY_FLOW_CONTROL = 12;
  localparam int B_COPY_OVERSIZE = 11;
  localparam int B_COPY_UNDERSIZE = 10;
  localparam int B_FORWARD_UNMONITORED = 8;
  localparam int F_PORT5_EGRESS_LO = 6;
  localparam int F_PORT5_INGRESS_LO = 4;
  localparam int F_PORT4_EGRESS_LO = 2;
  localparam int F_PORT4_INGRESS_LO = 0;
  localparam logic [15:0] MIRROR_CTRL_WMASK = 16'hFFFF;
  // ****************************************
  // copy selection codes, shared by both directions
  // ****************************************
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_ALL = 2'h1;
  localparam logic [1:0] SEL_DA_MATCH = 2'h2;
  localparam logic [1:0] SEL_SA_MATCH = 2'h3;
  // ****************************************
  // security status fields
  // ****************************************
  localparam int F_HIGH_FLAGS_LO = 6;
  localparam int F_LOW_FLAGS_LO = 0;
  localparam logic [2:0] LAST_PORT_CODE = 3'h5;
endpackage

/* File: tb/pmss_regs_asserts.sv */
// checker for the mirror and address security register bank
`timescale 1ns/1ps
module pmss_regs_asserts
  import pmss_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [pmss_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [pmss_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [pmss_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] monitor_port,
  input wire logic frm_valid,
  input wire logic [pmss_pkg::NPORT-1:0] frm_dst_ports,
  input wire logic frm_out_valid,
  input wire logic [pmss_pkg::NPORT-1:0] frm_out_ports,
  input wire logic frm_out_mirrored,
  input wire logic lock_lookup_start,
  input wire logic [2:0] lock_lookup_port
);
  import pmss_pkg::*;
  logic [5:0] dst_q;
  logic [5:0] mon_q;
  wire logic wr_srch = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr[11:2] == IDX_LOCK_SEARCH_PORT_SEL && s_axi_wstrb[0];
  // frame context kept so outputs can be judged a cycle later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dst_q <= 6'h00;
      mon_q <= 6'h00;
    end else if (frm_valid) begin
      dst_q <= frm_dst_ports;
      mon_q <= (monitor_port < 3'h6) ? 6'(6'h01 << monitor_port) : 6'h00;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  w_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  r_err_a: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  out_lat_a: assert property (frm_valid |=> frm_out_valid)
    else $error("frame result late");
  out_pulse_a: assert property (frm_out_valid |-> $past(frm_valid))
    else $error("frame result without frame");
  keep_ports_a: assert property (frm_out_valid |-> ((frm_out_ports ^ dst_q) & ~mon_q) == 6'h00)
    else $error("non-monitor ports altered");
  mir_on_a: assert property (frm_out_valid && frm_out_mirrored |-> (frm_out_ports & mon_q) == mon_q)
    else $error("mirrored frame misses monitor");
  mir_off_a: assert property (frm_out_valid && !frm_out_mirrored |-> (frm_out_ports & mon_q & ~dst_q) == 6'h00)
    else $error("unselected frame sent to monitor");
  srch_go_a: assert property (wr_srch && s_axi_wdata[2:0] <= LAST_PORT_CODE
    |=> lock_lookup_start && lock_lookup_port == $past(s_axi_wdata[2:0]))
    else $error("lookup not started");
  srch_skip_a: assert property (wr_srch && s_axi_wdata[2:0] > LAST_PORT_CODE
    |=> !lock_lookup_start && $stable(lock_lookup_port))
    else $error("lookup started on unused code");
  start_why_a: assert property (lock_lookup_start |-> $past(wr_srch))
    else $error("spurious lookup start");
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the mirror and address security register bank
`timescale 1ns/1ps
module tb_top;
  import pmss_pkg::*;
  localparam logic [11:0] A_MIR = {IDX_MIRROR_CTRL_UPPER, 2'b00};
  localparam logic [11:0] A_INT = {IDX_INTRUSION_FLAGS, 2'b00};
  localparam logic [11:0] A_ST1 = {IDX_LOCK_STATUS_FIRST, 2'b00};
  localparam logic [11:0] A_ST2 = {IDX_LOCK_STATUS_SECOND, 2'b00};
  localparam logic [11:0] A_SRC = {IDX_LOCK_SEARCH_PORT_SEL, 2'b00};
  logic clk, rst, awv, wv, brd, arv, rrd, awr, wr, bv, arr, rv, fv, fov, fom, lls;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd;
  logic [3:0] ws, s4;
  logic [1:0] br, rr;
  logic [15:0] lo, ctrl, d16;
  logic [2:0] mon, src, llp, e3;
  logic [5:0] dst, fop, ie, alf, pcf, llf, e6;
  logic [6:0] fl, e7;
  int fail_count, compares;
  pmss_regs pmss_regs_inst (.clk(clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd), .low_ports_copy_sel(lo),
    .monitor_port(mon), .frm_valid(fv), .frm_src_port(src), .frm_dst_ports(dst),
    .frm_da_match(fl[6]), .frm_sa_match(fl[5]), .frm_bad_checksum(fl[4]),
    .frm_receive_error(fl[3]), .frm_pause(fl[2]), .frm_oversize(fl[1]), .frm_undersize(fl[0]),
    .frm_out_valid(fov), .frm_out_ports(fop), .frm_out_mirrored(fom), .intrusion_evt(ie),
    .address_locked_flags(alf), .port_closed_flags(pcf), .link_lock_flags(llf),
    .lock_lookup_start(lls), .lock_lookup_port(llp));
  always #25 clk = ~clk;
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // every wait is bounded so a stuck handshake ends the run
  task automatic tick(inout int n);
    @(posedge clk);
    n++;
    if (n > 60) begin
      fail_count++;
      summarize();
    end
  endtask
  task automatic wchk(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s,
      input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    awa <= a;
    wd <= {16'h0, d};
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    brd <= 1'b1;
    // awv and wv still read high at the taking edge; the drop lands after it
    do begin
      tick(n);
      if (awr) awv <= 1'b0;
      if (wr) wv <= 1'b0;
    end while ((awv && !awr) || (wv && !wr));
    do tick(n); while (!bv);
    brd <= 1'b0;
    check({30'h0, br}, {30'h0, er});
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    do tick(n); while (!arr);
    arv <= 1'b0;
    do tick(n); while (!rv);
    rrd <= 1'b0;
    check({30'h0, rr}, {30'h0, er});
    check(rd, e);
  endtask
  function automatic logic hit(input logic [1:0] c, input logic da, input logic sa);
    return c == SEL_ALL || (c == SEL_DA_MATCH && da) || (c == SEL_SA_MATCH && sa);
  endfunction
  function automatic logic [6:0] exp_frm(input logic [15:0] c, input logic [15:0] l,
      input logic [2:0] m, input logic [2:0] s, input logic [5:0] d, input logic [6:0] f);
    logic [23:0] sel;
    logic h;
    logic [5:0] o;
    sel = {c[7:0], l};
    h = hit(sel[4*s +: 2], f[6], f[5]);
    for (int p = 0; p < 6; p++) if (d[p] && hit(sel[4*p+2 +: 2], f[6], f[5])) h = 1'b1;
    h = h && c[15] && ((f[4:0] & ~c[14:10]) == 5'h0);
    o = d;
    if (c[15] && m < 3'h6) o[m] = h || (c[8] && d[m]);
    return {h, o};
  endfunction
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {awv, wv, brd, arv, rrd, fv} = 6'h00;
    {awa, ara, wd, ws, lo, mon, src, dst, fl} = '0;
    {ie, alf, pcf, llf} = '0;
    fail_count = 0;
    compares = 0;
    ctrl = 16'h0000;
    e3 = 3'h0;
    void'($urandom(58561));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk(A_MIR, 32'h0, RESP_OKAY);
    rchk(A_SRC, 32'h0, RESP_OKAY);
    rchk(12'h000, 32'h0, RESP_SLVERR);
    wchk(12'h000, 16'hFFFF, 4'hF, RESP_SLVERR);
    alf <= 6'($urandom);
    pcf <= 6'($urandom);
    llf <= 6'($urandom);
    wchk(A_ST1, 16'hFFFF, 4'hF, RESP_OKAY);
    rchk(A_ST1, {20'h0, alf, pcf}, RESP_OKAY);
    rchk(A_ST2, {26'h0, llf}, RESP_OKAY);
    @(posedge clk);
    ie <= 6'h21;
    @(posedge clk);
    e6 = 6'($urandom);
    ie <= e6;
    e6 = e6 | 6'h21;
    @(posedge clk);
    ie <= 6'h00;
    rchk(A_INT, {20'h0, e6, 6'h0}, RESP_OKAY);
    rchk(A_INT, 32'h0, RESP_OKAY);
    for (int c = 0; c < 8; c++) begin
      wchk(A_SRC, {13'($urandom), 3'(c)}, 4'h1, RESP_OKAY);
      if (c < 6) e3 = 3'(c);
      check(32'(lls), 32'(c < 6));
      check({29'h0, llp}, {29'h0, e3});
      rchk(A_SRC, 32'(c), RESP_OKAY);
    end
    for (int i = 0; i < 300; i++) begin
      if (i % 30 == 0) begin
        d16 = (i == 0) ? 16'h0000 : (i == 30) ? 16'hFDFF : 16'($urandom);
        s4 = (i < 60) ? 4'h3 : 4'($urandom);
        wchk(A_MIR, d16, s4, RESP_OKAY);
        if (s4[0]) ctrl[7:0] = d16[7:0];
        if (s4[1]) ctrl[15:8] = d16[15:8];
        rchk(A_MIR, {16'h0, ctrl}, RESP_OKAY);
      end
      @(posedge clk);
      fv <= 1'b1;
      src <= 3'($urandom_range(5));
      dst <= 6'($urandom);
      mon <= 3'($urandom);
      lo <= 16'($urandom);
      // abnormal classes kept rare so ordinary selection gets exercised too
      fl <= {2'($urandom), 5'($urandom) & 5'($urandom) & 5'($urandom)};
      @(posedge clk);
      fv <= 1'b0;
      e7 = exp_frm(ctrl, lo, mon, src, dst, fl);
      @(posedge clk);
      check({31'h0, fov}, 32'h1);
      check({25'h0, fom, fop}, {25'h0, e7});
    end
    summarize();
  end
endmodule
bind pmss_regs pmss_regs_asserts pmss_regs_asserts_inst (.clk(clk), .rst(rst),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .monitor_port(monitor_port), .frm_valid(frm_valid), .frm_dst_ports(frm_dst_ports),
  .frm_out_valid(frm_out_valid), .frm_out_ports(frm_out_ports),
  .frm_out_mirrored(frm_out_mirrored), .lock_lookup_start(lock_lookup_start),
  .lock_lookup_port(lock_lookup_port));
